// File: rtl/bridge_hdr_pkg.sv
/*
 * Constants and carrier types for the bridge header register bank:
 * register offsets, field positions, reset and hardwired values, AXI
 * response codes and the structs that carry window and bus data.
 * Assumes a 32-bit AXI4-Lite register bus with one word per register.
 */
package bridge_hdr_pkg;

    // Byte addresses of the three words held here
    localparam logic [7:0] OFF_CACHE_LINE = 8'h0c;
    localparam logic [7:0] OFF_BUS_NUMS   = 8'h18;
    localparam logic [7:0] OFF_IO_BASE    = 8'h1c;

    // Reset and hardwired values
    localparam logic [7:0] CACHE_LINE_RST  = 8'h00;
    localparam logic [7:0] LAT_TIMER_VAL   = 8'h00;
    localparam logic [7:0] HDR_TYPE_VAL    = 8'h01;
    localparam logic [7:0] BUS_NUM_RST     = 8'h00;
    localparam logic [3:0] IO_WIDTH_FLAG   = 4'h1;
    localparam logic [3:0] IO_BOTTOM_RST   = 4'h0;

    // Field positions (low bit of each field)
    localparam int CLS_LSB      = 0;
    localparam int PLAT_LSB     = 8;
    localparam int HDR_LSB      = 16;
    localparam int UP_BUS_LSB   = 0;
    localparam int DN_BUS_LSB   = 8;
    localparam int HI_BUS_LSB   = 16;
    localparam int SLAT_LSB     = 24;
    localparam int IO_FLAG_LSB  = 0;
    localparam int IO_BOT_LSB   = 4;

    // Window low-order fill
    localparam logic [11:0] IO_BOTTOM_FILL = 12'h000;
    localparam logic [11:0] IO_TOP_FILL    = 12'hfff;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded register selector
    typedef enum logic [1:0] {
        SEL_NONE  = 2'h0,
        SEL_CLS   = 2'h1,
        SEL_BUS   = 2'h3,
        SEL_IO    = 2'h2
    } reg_sel_t;

    // Window pieces held by neighbouring registers
    typedef struct packed {
        logic [15:0] base_upper;  // Bottom address bits 31:16
        logic [15:0] limit_upper; // Top address bits 31:16
        logic [3:0]  limit_nib;   // Top address bits 15:12
    } io_ext_t;

    // Bus numbers handed to the routing logic
    typedef struct packed {
        logic [7:0] upstream;
        logic [7:0] downstream;
        logic [7:0] highest;
    } bus_nums_t;

endpackage : bridge_hdr_pkg

// File: rtl/bridge_header_bus_io_regs.sv
/*
 * Bridge header register bank: cache line size, latency timers, header
 * type, the three bus numbers and the I/O base register, reached over
 * AXI4-Lite, plus the I/O window check used to decide forwarding.
 * Assumes one clock (aclk), a synchronous active-low reset, and that the
 * I/O limit and upper-16 registers live in a neighbouring block on the
 * same clock, so their values arrive without synchronisers.
 */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module bridge_header_bus_io_regs #(
    parameter int ADDR_W = 8
) (
    input  wire logic                         aclk,          // Core clock
    input  wire logic                         aresetn,       // Sync reset, low
    input  wire logic                         clk_en,        // Freezes all state when low
    input  wire logic [ADDR_W-1:0]            s_axi_awaddr,  // Write address
    input  wire logic                         s_axi_awvalid, // Write address valid
    output logic                              s_axi_awready, // Write address ready
    input  wire logic [31:0]                  s_axi_wdata,   // Write data
    input  wire logic [3:0]                   s_axi_wstrb,   // Byte enables
    input  wire logic                         s_axi_wvalid,  // Write data valid
    output logic                              s_axi_wready,  // Write data ready
    output logic [1:0]                        s_axi_bresp,   // Write response
    output logic                              s_axi_bvalid,  // Write response valid
    input  wire logic                         s_axi_bready,  // Write response ready
    input  wire logic [ADDR_W-1:0]            s_axi_araddr,  // Read address
    input  wire logic                         s_axi_arvalid, // Read address valid
    output logic                              s_axi_arready, // Read address ready
    output logic [31:0]                       s_axi_rdata,   // Read data
    output logic [1:0]                        s_axi_rresp,   // Read response
    output logic                              s_axi_rvalid,  // Read data valid
    input  wire logic                         s_axi_rready,  // Read data ready
    input  wire bridge_hdr_pkg::io_ext_t      io_ext,        // Neighbouring window fields
    input  wire logic                         io_chk_valid,  // I/O address to check
    input  wire logic [31:0]                  io_chk_addr,   // Address under check
    output logic                              io_hit_valid,  // Check result strobe
    output logic                              io_hit,        // Address inside window
    output logic [31:0]                       io_bottom,     // Window bottom address
    output logic [31:0]                       io_top,        // Window top address
    output bridge_hdr_pkg::bus_nums_t         bus_nums       // Programmed bus numbers
);

    // Map a byte address to a register; low two bits are ignored
    function automatic bridge_hdr_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = 8'(a) & 8'hfc;
        if (ADDR_W > 8 && (a >> 8) != '0) begin
            decode = bridge_hdr_pkg::SEL_NONE;
        end else if (w == bridge_hdr_pkg::OFF_CACHE_LINE) begin
            decode = bridge_hdr_pkg::SEL_CLS;
        end else if (w == bridge_hdr_pkg::OFF_BUS_NUMS) begin
            decode = bridge_hdr_pkg::SEL_BUS;
        end else if (w == bridge_hdr_pkg::OFF_IO_BASE) begin
            decode = bridge_hdr_pkg::SEL_IO;
        end else begin
            decode = bridge_hdr_pkg::SEL_NONE;
        end
    endfunction : decode

    // Stored fields
    logic [7:0]        cache_line_size_r;
    logic [7:0]        upstream_bus_r;
    logic [7:0]        downstream_bus_r;
    logic [7:0]        highest_bus_r;
    logic [3:0]        io_window_bottom_r;

    // Write channel holding state
    logic              aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic              w_held_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;

    // Read channel state
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    // Window check result
    logic              hit_valid_r;
    logic              hit_r;

    logic              wr_go;
    bridge_hdr_pkg::reg_sel_t wr_sel;
    bridge_hdr_pkg::reg_sel_t rd_sel;
    logic [31:0]       rd_word;
    logic [31:0]       bottom_addr;
    logic [31:0]       top_addr;

    // Readies drop while the clock enable is low so no beat is lost
    assign s_axi_awready = clk_en && !aw_held_r && !bvalid_r;
    assign s_axi_wready  = clk_en && !w_held_r && !bvalid_r;
    assign s_axi_arready = clk_en && !rvalid_r;

    // Both halves of a write present, no response pending
    assign wr_go  = clk_en && aw_held_r && w_held_r && !bvalid_r;
    assign wr_sel = decode(aw_addr_r);
    assign rd_sel = decode(s_axi_araddr);

    // Capture write address; either channel may arrive first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    // Capture write data and strobes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped words answer SLVERR and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= bridge_hdr_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (wr_sel == bridge_hdr_pkg::SEL_NONE) ?
                            bridge_hdr_pkg::RESP_SLVERR : bridge_hdr_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Cache line size: kept for legacy software, drives no logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cache_line_size_r <= bridge_hdr_pkg::CACHE_LINE_RST;
        end else if (wr_go && wr_sel == bridge_hdr_pkg::SEL_CLS && w_strb_r[0]) begin
            cache_line_size_r <= w_data_r[bridge_hdr_pkg::CLS_LSB +: 8];
        end
    end

    // Bus numbers; the latency timer lane is read-only and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upstream_bus_r   <= bridge_hdr_pkg::BUS_NUM_RST;
            downstream_bus_r <= bridge_hdr_pkg::BUS_NUM_RST;
            highest_bus_r    <= bridge_hdr_pkg::BUS_NUM_RST;
        end else if (wr_go && wr_sel == bridge_hdr_pkg::SEL_BUS) begin
            if (w_strb_r[0]) begin
                upstream_bus_r <= w_data_r[bridge_hdr_pkg::UP_BUS_LSB +: 8];
            end
            if (w_strb_r[1]) begin
                downstream_bus_r <= w_data_r[bridge_hdr_pkg::DN_BUS_LSB +: 8];
            end
            if (w_strb_r[2]) begin
                highest_bus_r <= w_data_r[bridge_hdr_pkg::HI_BUS_LSB +: 8];
            end
        end
    end

    // I/O window bottom nibble; the width flag nibble is hardwired
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_window_bottom_r <= bridge_hdr_pkg::IO_BOTTOM_RST;
        end else if (wr_go && wr_sel == bridge_hdr_pkg::SEL_IO && w_strb_r[0]) begin
            io_window_bottom_r <= w_data_r[bridge_hdr_pkg::IO_BOT_LSB +: 4];
        end
    end

    // Read word assembly; unowned bytes of each word read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            bridge_hdr_pkg::SEL_CLS: begin
                rd_word[bridge_hdr_pkg::CLS_LSB +: 8]  = cache_line_size_r;
                rd_word[bridge_hdr_pkg::PLAT_LSB +: 8] = bridge_hdr_pkg::LAT_TIMER_VAL;
                rd_word[bridge_hdr_pkg::HDR_LSB +: 8]  = bridge_hdr_pkg::HDR_TYPE_VAL;
            end
            bridge_hdr_pkg::SEL_BUS: begin
                rd_word[bridge_hdr_pkg::UP_BUS_LSB +: 8] = upstream_bus_r;
                rd_word[bridge_hdr_pkg::DN_BUS_LSB +: 8] = downstream_bus_r;
                rd_word[bridge_hdr_pkg::HI_BUS_LSB +: 8] = highest_bus_r;
                rd_word[bridge_hdr_pkg::SLAT_LSB +: 8]   = bridge_hdr_pkg::LAT_TIMER_VAL;
            end
            bridge_hdr_pkg::SEL_IO: begin
                rd_word[bridge_hdr_pkg::IO_FLAG_LSB +: 4] = bridge_hdr_pkg::IO_WIDTH_FLAG;
                rd_word[bridge_hdr_pkg::IO_BOT_LSB +: 4]  = io_window_bottom_r;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Read channel: one read in flight, data registered at acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= bridge_hdr_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_word;
                rresp_r  <= (rd_sel == bridge_hdr_pkg::SEL_NONE) ?
                            bridge_hdr_pkg::RESP_SLVERR : bridge_hdr_pkg::RESP_OKAY;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Window edges: bottom fills low bits with zeros, top with ones
    assign bottom_addr = {io_ext.base_upper, io_window_bottom_r,
                          bridge_hdr_pkg::IO_BOTTOM_FILL};
    assign top_addr    = {io_ext.limit_upper, io_ext.limit_nib,
                          bridge_hdr_pkg::IO_TOP_FILL};

    // Forwarding check, registered so the result is glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_valid_r <= 1'b0;
            hit_r       <= 1'b0;
        end else if (clk_en) begin
            hit_valid_r <= io_chk_valid;
            if (io_chk_valid) begin
                hit_r <= (io_chk_addr >= bottom_addr) &&
                         (io_chk_addr <= top_addr);
            end
        end
    end

    // Outputs
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;
    assign io_hit_valid = hit_valid_r;
    assign io_hit       = hit_r;
    assign io_bottom    = bottom_addr; // Window edges track registers directly
    assign io_top       = top_addr;
    assign bus_nums     = '{upstream:   upstream_bus_r,
                            downstream: downstream_bus_r,
                            highest:    highest_bus_r};

endmodule : bridge_header_bus_io_regs

`default_nettype wire

// File: test/bridge_hdr_assertions.sv
/* Checker for the bridge header bank: bus answer timing, read map, window.
   Assumes clk_en is held high and sees only the top module's ports. */
`timescale 1ns/1ps
`default_nettype none
module bridge_hdr_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic                      aclk,          // Clock
    input wire logic                      aresetn,       // Reset
    input wire logic                      s_axi_awvalid, // AW valid
    input wire logic                      s_axi_awready, // AW ready
    input wire logic                      s_axi_wvalid,  // W valid
    input wire logic                      s_axi_wready,  // W ready
    input wire logic                      s_axi_bvalid,  // B valid
    input wire logic [ADDR_W-1:0]         s_axi_araddr,  // AR addr
    input wire logic                      s_axi_arvalid, // AR valid
    input wire logic                      s_axi_arready, // AR ready
    input wire logic [31:0]               s_axi_rdata,   // R data
    input wire logic [1:0]                s_axi_rresp,   // R resp
    input wire logic                      s_axi_rvalid,  // R valid
    input wire logic                      s_axi_rready,  // R ready
    input wire bridge_hdr_pkg::io_ext_t   io_ext,        // Window parts
    input wire logic                      io_chk_valid,  // Check strobe
    input wire logic [31:0]               io_chk_addr,   // Check addr
    input wire logic                      io_hit_valid,  // Result strobe
    input wire logic                      io_hit,        // Result
    input wire logic [31:0]               io_bottom,     // Bottom
    input wire logic [31:0]               io_top,        // Top
    input wire bridge_hdr_pkg::bus_nums_t bus_nums       // Bus numbers
);
    logic [ADDR_W-1:0] ar_q_r; // Word of the read in flight

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Keep the read address so the answer can be judged by word
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ar_q_r <= s_axi_araddr;
        end
    end

    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_r_stand;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("read data dropped");
    property p_cls_word;
        s_axi_rvalid && ar_q_r == 8'h0c |-> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h000100;
    endproperty
    a_cls_word: assert property (p_cls_word) else $error("fixed bytes wrong");
    property p_bus_word;
        s_axi_rvalid && ar_q_r == 8'h18 |-> s_axi_rdata == {8'h00, bus_nums.highest,
            bus_nums.downstream, bus_nums.upstream};
    endproperty
    a_bus_word: assert property (p_bus_word) else $error("bus word wrong");
    property p_io_word;
        s_axi_rvalid && ar_q_r == 8'h1c |-> s_axi_rdata == {24'h0, io_bottom[15:12], 4'h1};
    endproperty
    a_io_word: assert property (p_io_word) else $error("io base word wrong");
    property p_fill;
        io_bottom[11:0] == 12'h000 && io_bottom[31:16] == io_ext.base_upper &&
        io_top == {io_ext.limit_upper, io_ext.limit_nib, 12'hfff};
    endproperty
    a_fill: assert property (p_fill) else $error("window fill wrong");
    // Judged against the window as it stood in the checking cycle
    property p_hit;
        io_chk_valid |=> io_hit_valid && io_hit == ($past(io_chk_addr) >= $past(io_bottom)
            && $past(io_chk_addr) <= $past(io_top));
    endproperty
    a_hit: assert property (p_hit) else $error("window result wrong");
    property p_rst;
        disable iff (1'b0) !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && !io_hit_valid &&
            bus_nums == 24'h000000 && io_bottom[15:12] == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_hit: cover property (io_hit_valid && io_hit);
    c_miss: cover property (io_hit_valid && !io_hit);
    c_r_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : bridge_hdr_assertions

bind bridge_header_bus_io_regs bridge_hdr_assertions #(.ADDR_W(ADDR_W)) chk_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .io_ext(io_ext),
    .io_chk_valid(io_chk_valid), .io_chk_addr(io_chk_addr), .io_hit_valid(io_hit_valid),
    .io_hit(io_hit), .io_bottom(io_bottom), .io_top(io_top), .bus_nums(bus_nums)
);
`default_nettype wire

// File: test/tb.sv
/* Self-checking bench for the bridge header bank: register access over
   AXI4-Lite, reset values, read-only bytes, unmapped words, window check.
   Assumes the checker is bound in from its own file; clk_en stays high. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        aclk, aresetn, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, chk_v, hit_v, hit;
    logic [7:0]  awaddr, araddr, cls_m;
    logic [3:0]  wstrb, nib_m;
    logic [1:0]  bresp, rresp;
    logic [31:0] wdata, rdata, chk_a, bottom, top;
    logic [23:0] bus_m;
    logic [33:0] exp_q[$];  // Expected {resp, data}, oldest first
    logic [7:0]  offs[5] = '{8'h0c, 8'h18, 8'h1c, 8'h10, 8'h80};
    integer      seed = 83;
    int          err_count = 0, samples_checked = 0, cycles = 0;
    bridge_hdr_pkg::io_ext_t   io_ext;
    bridge_hdr_pkg::bus_nums_t bus_nums;

    bridge_header_bus_io_regs bridge_header_bus_io_regs_i (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_ext(io_ext),
        .io_chk_valid(chk_v), .io_chk_addr(chk_a), .io_hit_valid(hit_v),
        .io_hit(hit), .io_bottom(bottom), .io_top(top), .bus_nums(bus_nums)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // Expected word from the bank model; unmapped words answer an error
    function automatic logic [33:0] word(input logic [7:0] a);
        case (a)
            8'h0c:   word = {18'h00001, 8'h00, cls_m};
            8'h18:   word = {10'h000, bus_m};
            8'h1c:   word = {26'h0, nib_m, 4'h1};
            default: word = {2'h2, 32'h0};
        endcase
    endfunction : word

    // Address and data offered together, response taken after a random stall
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        exp_q.push_back({word(a) == {2'h2, 32'h0} ? 2'h2 : 2'h0, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge aclk);
        if (a == 8'h0c && s[0]) cls_m = d[7:0];
        for (int i = 0; i < 3; i++) if (a == 8'h18 && s[i]) bus_m[8*i +: 8] = d[8*i +: 8];
        if (a == 8'h1c && s[0]) nib_m = d[7:4];
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        exp_q.push_back(word(a));
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // Back-to-back checks at both edges of a random window, one per cycle
    task automatic win_run(input int n);
        logic [31:0] r, lo, hi, x;
        r = $random(seed);
        io_ext <= {r[15:0], r[15:0], r[19:16]};
        lo = {r[15:0], nib_m, 12'h000};
        hi = {r[15:0], r[19:16], 12'hfff};
        for (int i = 0; i < n; i++) begin
            x = (i % 3 == 0) ? lo - 32'(i % 2) : (i % 3 == 1) ? hi + 32'(i % 2) : $random(seed);
            exp_q.push_back({33'h0, (x >= lo && x <= hi)});
            chk_v <= 1'b1;
            chk_a <= x;
            @(posedge aclk);
        end
        chk_v <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : win_run

    // Each answer takes the oldest note; a missing note reads as all ones
    task automatic pop_check(input string what, input logic [33:0] seen);
        check(what, seen, exp_q.size() > 0 ? exp_q.pop_front() : '1);
    endtask : pop_check

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
        if ((aresetn & bvalid & bready) === 1'b1) pop_check("bresp", {bresp, 32'h0});
        if ((aresetn & rvalid & rready) === 1'b1) pop_check("read", {rresp, rdata});
        if ((aresetn & hit_v) === 1'b1) pop_check("io_hit", {33'h0, hit});
    end

    initial begin
        logic [31:0] d;
        logic [7:0]  a;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, chk_v} = '0;
        {awaddr, araddr, wdata, wstrb, chk_a} = '0;
        io_ext = '0;
        clk_en = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Second pass follows a mid-run reset and must see reset values again
        for (int pass = 0; pass < 2; pass++) begin
            {cls_m, bus_m, nib_m} = '0;
            foreach (offs[k]) axi_rd(offs[k]);
            foreach (offs[k]) axi_wr(offs[k], 32'hffffffff, 4'hf);
            foreach (offs[k]) axi_rd(offs[k]);
            repeat (12) begin
                a = offs[$unsigned($random(seed)) % 5];
                d = $random(seed);
                axi_wr(a, d, d[11:8]);
                axi_rd(a);
            end
            win_run(9);
            aresetn <= 1'b0;
            repeat (2) @(posedge aclk);
            aresetn <= 1'b1;
            @(posedge aclk);
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
